/* logic/mpo_output_stage.sv */
// Motor PWM output stage: control, protection, dead time
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module mpo_output_stage (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Sync reset, active high
    input wire logic ce_i, // Clock enable, freezes state
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write
    input wire logic [mpo_pkg::ADR_W-1:0] wb_adr_i, // Byte address
    input wire logic [31:0] wb_dat_i, // Write data
    input wire logic [3:0] wb_sel_i, // Byte lanes
    output logic [31:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic [2:0] pwm_i, // Carrier compare, w v u
    input wire logic cnt_min_i, // Carrier at minimum pulse
    input wire logic cnt_max_i, // Carrier at maximum pulse
    input wire logic fault_n_i, // Emergency input pin
    input wire logic halt_i, // Debug break halt
    output logic [5:0] gate_o, // Gates, pairs upper/lower u v w
    output logic port_hiz_o, // Ports to high impedance
    output logic pwm_irq_o, // PWM interrupt pulse
    output logic protect_irq_o // Emergency interrupt pulse
);
    import mpo_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Register state

    logic ack_reg;
    logic [31:0] dat_reg;
    logic [1:0] rate_reg;
    logic sync_trigger_mode;
    logic wave_output_enable;
    logic [8:0] out_shadow_reg;
    logic [8:0] out_active_reg;
    logic [1:0] output_update_timing;
    logic lower_arm_polarity;
    logic upper_arm_polarity;
    logic protect_enable;
    logic [1:0] protect_mode;
    logic break_port_mode;
    logic [DT_W-1:0] dead_time_reg;
    mpo_key_e key_reg;
    mpo_key_e key_next;
    logic protect_active_flag;
    logic fault_s1_reg;
    logic fault_s2_reg;
    logic fault_s3_reg;
    logic [1:0] min_cnt_reg;
    logic [5:0] gate_reg;
    logic [5:0] gate_next;
    logic hiz_reg;
    logic pwm_irq_reg;
    logic protect_irq_reg;

    ////////////////////////////////////////////////////////////////
    // Bus decode

    logic req;
    logic wr;
    logic wr_lo;
    logic [ADR_W-1:0] adr_word;
    logic hit_unit;
    logic hit_out;
    logic hit_pot;
    logic hit_key;
    logic hit_pctl;
    logic hit_psta;
    logic hit_brk;
    logic hit_dt;
    logic [31:0] rd_data;

    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr = req & wb_we_i;
    assign wr_lo = wr & wb_sel_i[0];
    assign adr_word = {wb_adr_i[ADR_W-1:2], 2'b00};
    assign hit_unit = adr_word == OFS_UNIT;
    assign hit_out = adr_word == OFS_OUT;
    assign hit_pot = adr_word == OFS_POT;
    assign hit_key = adr_word == OFS_KEY;
    assign hit_pctl = adr_word == OFS_PCTL;
    assign hit_psta = adr_word == OFS_PSTA;
    assign hit_brk = adr_word == OFS_BRK;
    assign hit_dt = adr_word == OFS_DT;

    // Key and unmapped addresses read zero
    assign rd_data =
        hit_unit ? {28'h0, wave_output_enable, sync_trigger_mode,
                    rate_reg} :
        hit_out ? {23'h0, out_shadow_reg} :
        hit_pot ? {28'h0, upper_arm_polarity, lower_arm_polarity,
                   output_update_timing} :
        hit_pctl ? {27'h0, protect_mode, 2'b00, protect_enable} :
        hit_psta ? {30'h0, fault_s2_reg, protect_active_flag} :
        hit_brk ? {31'h0, break_port_mode} :
        hit_dt ? {24'h0, dead_time_reg} :
        32'h0;

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0;
        end
        else if (ce_i)
        begin
            ack_reg <= req;
            dat_reg <= (req & ~wb_we_i) ? rd_data : 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [8:0] out_wr;
    logic upd_now;

    assign out_wr = {wb_sel_i[1] ? wb_dat_i[8] : out_shadow_reg[8],
                     wb_sel_i[0] ? wb_dat_i[7:0] : out_shadow_reg[7:0]};
    assign upd_now = (output_update_timing == UPD_WRITE) |
                     (output_update_timing[0] & cnt_min_i) |
                     (output_update_timing[1] & cnt_max_i);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            rate_reg <= RST_RATE;
            sync_trigger_mode <= 1'b0;
            wave_output_enable <= 1'b0;
            out_shadow_reg <= RST_OUT;
            output_update_timing <= RST_UPD;
            lower_arm_polarity <= RST_POL;
            upper_arm_polarity <= RST_POL;
            protect_mode <= RST_PMODE;
            break_port_mode <= RST_BRK;
            dead_time_reg <= RST_DT;
        end
        else if (ce_i && wr_lo)
        begin
            if (hit_unit)
            begin
                rate_reg <= wb_dat_i[UNIT_RATE_LSB +: 2];
                sync_trigger_mode <= wb_dat_i[UNIT_SYNC_BIT];
                wave_output_enable <= wb_dat_i[UNIT_EN_BIT];
            end
            if (hit_out)
                out_shadow_reg <= out_wr;
            if (hit_pot)
            begin
                output_update_timing <= wb_dat_i[POT_UPD_LSB +: 2];
                lower_arm_polarity <= wb_dat_i[POT_LO_BIT];
                upper_arm_polarity <= wb_dat_i[POT_HI_BIT];
            end
            if (hit_pctl)
                protect_mode <= wb_dat_i[PCTL_MODE_LSB +: 2];
            if (hit_brk)
                break_port_mode <= wb_dat_i[0];
            if (hit_dt)
                dead_time_reg <= wb_dat_i[DT_W-1:0];
        end
    end

    // Second buffer stage feeding the output logic
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            out_active_reg <= RST_OUT;
        else if (ce_i && upd_now)
            out_active_reg <= out_shadow_reg;
    end

    ////////////////////////////////////////////////////////////////
    // Keyed disable of protection

    logic dis_ok;
    logic pen_next;

    always_comb
    begin
        key_next = key_reg;
        if (wr)
        begin
            unique case (key_reg)
                KEY_IDLE:
                    key_next = (hit_key && wb_dat_i[7:0] == KEY_FIRST) ?
                               KEY_ONE : KEY_IDLE;
                KEY_ONE:
                    key_next = (hit_key && wb_dat_i[7:0] == KEY_SECOND) ?
                               KEY_TWO : KEY_IDLE;
                KEY_TWO:
                    key_next = KEY_IDLE;
                default:
                    key_next = KEY_IDLE;
            endcase
        end
    end

    assign dis_ok = (key_reg == KEY_TWO) & wr_lo & hit_pctl;
    assign pen_next = ~(wr_lo & hit_pctl) ? protect_enable :
                      wb_dat_i[PCTL_EN_BIT] ? 1'b1 :
                      dis_ok ? 1'b0 : protect_enable;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            key_reg <= KEY_IDLE;
            protect_enable <= RST_PEN;
        end
        else if (ce_i)
        begin
            key_reg <= key_next;
            protect_enable <= pen_next;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Emergency protection

    logic fault_fall;
    logic prot_set;
    logic rel_ok;
    logic forced;

    assign fault_fall = fault_s3_reg & ~fault_s2_reg;
    assign prot_set = fault_fall & protect_enable;
    assign rel_ok = wr_lo & hit_pctl & wb_dat_i[PCTL_REL_BIT] &
                    fault_s2_reg;
    assign forced = protect_active_flag | halt_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_s1_reg <= 1'b1;
            fault_s2_reg <= 1'b1;
            fault_s3_reg <= 1'b1;
            protect_active_flag <= 1'b0;
            protect_irq_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            fault_s1_reg <= fault_n_i;
            fault_s2_reg <= fault_s1_reg;
            fault_s3_reg <= fault_s2_reg;
            // Set wins over a release in the same cycle
            protect_active_flag <= prot_set |
                (protect_active_flag & ~rel_ok);
            protect_irq_reg <= prot_set;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Carrier-synchronous interrupt

    logic irq_evt;

    assign irq_evt = (rate_reg == RATE_HALF) ? (cnt_min_i | cnt_max_i) :
                     (rate_reg == RATE_ONE) ? cnt_min_i :
                     (rate_reg == RATE_TWO) ? cnt_min_i & ~min_cnt_reg[0] :
                     cnt_min_i & (min_cnt_reg == 2'h0);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            min_cnt_reg <= 2'h0;
            pwm_irq_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            if (cnt_min_i)
                min_cnt_reg <= min_cnt_reg + 2'h1;
            pwm_irq_reg <= irq_evt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Per-phase output control, dead time and polarity

    logic [DTC_W-1:0] dt_cyc;

    assign dt_cyc = DTC_W'(dead_time_reg) * DTC_W'(DT_STEP_CYC);

    for (genvar ph = 0; ph < 3; ph++)
    begin : g_phase
        logic [1:0] code;
        logic wave;
        logic p;
        logic hi_raw;
        logic lo_raw;
        logic hi_req;
        logic lo_req;
        logic hi_on;
        logic lo_on;

        assign code = out_active_reg[2*ph +: 2];
        assign wave = out_active_reg[OUT_WAVE_LSB + ph];
        assign p = pwm_i[ph];
        // Level mode drives the code bits as fixed levels
        assign hi_raw = ~wave ? code[1] :
                        (code == 2'b00) ? ~p :
                        (code == 2'b01) ? 1'b0 : p;
        assign lo_raw = ~wave ? code[0] :
                        (code == 2'b00) ? p :
                        (code == 2'b01) ?
                            ((sync_trigger_mode & lower_arm_polarity) ?
                             ~p : p) :
                        (code == 2'b10) ? 1'b0 : ~p;
        // Forced on is plain PWM pair, forced off turns both arms off
        assign hi_req = forced ? (~protect_mode[0] & p) :
                        (wave_output_enable & hi_raw);
        assign lo_req = forced ? (~protect_mode[0] & ~p) :
                        (wave_output_enable & lo_raw);

        mpo_dead_time u_dead (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .dt_cyc_i(dt_cyc),
            .hi_req_i(hi_req),
            .lo_req_i(lo_req),
            .hi_on_o(hi_on),
            .lo_on_o(lo_on)
        );

        assign gate_next[2*ph] = upper_arm_polarity ? hi_on : ~hi_on;
        assign gate_next[2*ph+1] = lower_arm_polarity ? lo_on : ~lo_on;
    end

    ////////////////////////////////////////////////////////////////
    // Output flops

    logic hiz_next;

    assign hiz_next = (protect_active_flag &
                       (protect_mode != PMODE_ON_PORT)) |
                      (halt_i & break_port_mode);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gate_reg <= 6'h00;
            hiz_reg <= 1'b0;
        end
        else if (ce_i)
        begin
            gate_reg <= gate_next;
            hiz_reg <= hiz_next;
        end
    end

    assign gate_o = gate_reg;
    assign port_hiz_o = hiz_reg;
    assign pwm_irq_o = pwm_irq_reg;
    assign protect_irq_o = protect_irq_reg;

    ////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || !ce_i);

    sequence s_fault_fall;
        fault_s3_reg && !fault_s2_reg;
    endsequence

    sequence s_entered;
        protect_active_flag && protect_irq_reg;
    endsequence

    property p_enter;
        (s_fault_fall and protect_enable) |=> s_entered;
    endproperty
    a_enter: assert property (p_enter)
        else $error("fault edge did not enter protection");

    property p_hold;
        (protect_active_flag && !rel_ok) |=> protect_active_flag;
    endproperty
    a_hold: assert property (p_hold)
        else $error("protection left without release");

    property p_rel_low;
        (protect_active_flag && !fault_s2_reg) |=> protect_active_flag;
    endproperty
    a_rel_low: assert property (p_rel_low)
        else $error("release taken while fault input low");

    property p_disabled;
        (!protect_enable && !protect_active_flag) |=>
            (!protect_active_flag && !protect_irq_reg);
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled protection reacted to fault");

    property p_key;
        (wr_lo && hit_pctl && key_reg != KEY_TWO && protect_enable)
            |=> protect_enable;
    endproperty
    a_key: assert property (p_key)
        else $error("protection disabled without key sequence");

    property p_status;
        (req && !wb_we_i && hit_psta) |=>
            (wb_ack_o && wb_dat_o[0] == $past(protect_active_flag));
    endproperty
    a_status: assert property (p_status)
        else $error("status bit differs from protection state");

    property p_hiz;
        (protect_active_flag && protect_mode != PMODE_ON_PORT)
            |=> port_hiz_o;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("ports not high impedance under protection");

    property p_update;
        (output_update_timing == 2'b01 && cnt_min_i) |=>
            (out_active_reg == $past(out_shadow_reg));
    endproperty
    a_update: assert property (p_update)
        else $error("output setting not loaded at minimum");

    property p_half_irq;
        (rate_reg == RATE_HALF && (cnt_min_i || cnt_max_i))
            |=> pwm_irq_o;
    endproperty
    a_half_irq: assert property (p_half_irq)
        else $error("half-period interrupt missing");

endmodule

/* logic/mpo_pkg.sv */
// Constants and types of the motor PWM output stage
// Summary of operation
// - PWM interrupt at half, one, two, four periods
// - Output settings double buffered, immediate or carrier-synced
// - Upper and lower arm polarity chosen separately
// - Each phase drives PWM or fixed level
// - Level and PWM code tables, active-high polarity
// - Active-low inverts; sync mode inverts lower 01 when the lower arm is active-high
// - Fault falling edge forces outputs, raises interrupt
// - Port high impedance per protection mode
// - Debug break forces outputs; port mode selects hiz
// - Status bit reads 1 while protected
// - Release ignored while fault input low
// - Disable needs keys 5a, a5, then clear
// - Dead time delays turn-on edge per phase
// - Dead time is 8 bits, 100ns steps
// - Protection mode encodes phase on/off and hiz
// - Update timing: write, minimum, maximum, both
package mpo_pkg;

    localparam int ADR_W = 8;
    localparam int CLK_MHZ = 40;
    localparam int DT_STEP_NS = 100;
    localparam int DT_STEP_CYC = (DT_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int DT_W = 8;
    localparam int DTC_W = 10;

    localparam logic [ADR_W-1:0] OFS_UNIT = 8'h00;
    localparam logic [ADR_W-1:0] OFS_OUT = 8'h04;
    localparam logic [ADR_W-1:0] OFS_POT = 8'h08;
    localparam logic [ADR_W-1:0] OFS_KEY = 8'h0c;
    localparam logic [ADR_W-1:0] OFS_PCTL = 8'h10;
    localparam logic [ADR_W-1:0] OFS_PSTA = 8'h14;
    localparam logic [ADR_W-1:0] OFS_BRK = 8'h18;
    localparam logic [ADR_W-1:0] OFS_DT = 8'h1c;

    localparam int UNIT_RATE_LSB = 0;
    localparam int UNIT_SYNC_BIT = 2;
    localparam int UNIT_EN_BIT = 3;
    localparam int OUT_WAVE_LSB = 6;
    localparam int POT_UPD_LSB = 0;
    localparam int POT_LO_BIT = 2;
    localparam int POT_HI_BIT = 3;
    localparam int PCTL_EN_BIT = 0;
    localparam int PCTL_REL_BIT = 1;
    localparam int PCTL_MODE_LSB = 3;

    localparam logic [1:0] RST_RATE = 2'h0;
    localparam logic [8:0] RST_OUT = 9'h000;
    localparam logic [1:0] RST_UPD = 2'h0;
    localparam logic RST_POL = 1'b0;
    localparam logic RST_PEN = 1'b1;
    localparam logic [1:0] RST_PMODE = 2'h3;
    localparam logic RST_BRK = 1'b1;
    localparam logic [DT_W-1:0] RST_DT = 8'h00;

    localparam logic [7:0] KEY_FIRST = 8'h5a;
    localparam logic [7:0] KEY_SECOND = 8'ha5;

    localparam logic [1:0] RATE_HALF = 2'h0;
    localparam logic [1:0] RATE_ONE = 2'h1;
    localparam logic [1:0] RATE_TWO = 2'h2;
    localparam logic [1:0] UPD_WRITE = 2'h0;
    localparam logic [1:0] PMODE_ON_PORT = 2'h2;

    typedef enum logic [1:0] {KEY_IDLE, KEY_ONE, KEY_TWO} mpo_key_e;

endpackage

/* logic/mpo_dead_time.sv */
// Dead-time insertion for one phase
`timescale 1ns/1ps
module mpo_dead_time (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Sync reset, active high
    input wire logic ce_i, // Clock enable
    input wire logic [mpo_pkg::DTC_W-1:0] dt_cyc_i, // Dead time in cycles
    input wire logic hi_req_i, // Upper arm on request
    input wire logic lo_req_i, // Lower arm on request
    output logic hi_on_o, // Upper arm on after dead time
    output logic lo_on_o // Lower arm on after dead time
);
    import mpo_pkg::*;

    logic [DTC_W-1:0] cnt_reg;
    logic [DTC_W-1:0] cnt_next;
    logic [1:0] prev_reg;
    logic changed;

    assign changed = {hi_req_i, lo_req_i} != prev_reg;
    // Reload on every swap, so turn-on waits; turn-off passes at once
    assign cnt_next = changed ? dt_cyc_i :
                      (cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= '0;
            prev_reg <= 2'h0;
            hi_on_o <= 1'b0;
            lo_on_o <= 1'b0;
        end
        else if (ce_i)
        begin
            cnt_reg <= cnt_next;
            prev_reg <= {hi_req_i, lo_req_i};
            hi_on_o <= hi_req_i & (cnt_next == '0);
            lo_on_o <= lo_req_i & (cnt_next == '0);
        end
    end

    property p_dt_delay;
        @(posedge clk_i) disable iff (rst_i || !ce_i)
        (changed && dt_cyc_i != '0) |=> (!hi_on_o && !lo_on_o);
    endproperty
    a_dt_delay: assert property (p_dt_delay)
        else $error("turn-on not delayed by dead time");

endmodule

/* verification/mpo_inv_model.sv */
// Inverter side: gate pins as seen by the drivers, and the fault pin
`timescale 1ns/1ps
module mpo_inv_model (
    input wire logic trip_i, // Bench asks for a fault
    input wire logic port_hiz_i, // Ports released
    input wire logic [5:0] gate_i, // Gate outputs of the stage
    output logic fault_n_o, // Fault pin, low = fault
    output logic [5:0] pin_o // Gate level at the drivers
);
    // Fault pin pulled up, pulled low while tripped
    assign fault_n_o = ~trip_i;
    // Pull-downs hold the gates off once the port is released
    assign pin_o = port_hiz_i ? 6'h00 : gate_i;
endmodule

/* verification/motor_pwm_output_stage_tb_top.sv */
// Self-checking bench of the motor PWM output stage
`timescale 1ns/1ps
module motor_pwm_output_stage_tb_top;
    import mpo_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [2:0] pwm = 3'h0;
    logic cmin = 1'b0;
    logic cmax = 1'b0;
    logic trip = 1'b0;
    logic halt = 1'b0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic [5:0] gate;
    logic [5:0] pin;
    logic [5:0] g;
    logic ack, fault_n, hiz, pirq, eirq;
    int err_total = 0;
    int checks = 0;
    int pirq_n = 0;
    int eirq_n = 0;
    int n;
    logic [31:0] rst_exp [9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h19,
        32'h2, 32'h1, 32'h0, 32'h0};

    always #12.5 clk_i = ~clk_i;

    always @(posedge clk_i)
    begin
        pirq_n += int'(pirq === 1'b1);
        eirq_n += int'(eirq === 1'b1);
    end

    mpo_output_stage i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
        .pwm_i(pwm), .cnt_min_i(cmin), .cnt_max_i(cmax),
        .fault_n_i(fault_n), .halt_i(halt), .gate_o(gate),
        .port_hiz_o(hiz), .pwm_irq_o(pirq), .protect_irq_o(eirq)
    );

    mpo_inv_model i_inv (
        .trip_i(trip), .port_hiz_i(hiz), .gate_i(gate),
        .fault_n_o(fault_n), .pin_o(pin)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
    endtask

    // One classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hf};
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (ack !== 1'b1 && t < 50);
        q = rdat;
        {cyc, stb, we} <= 3'h0;
        if (ack !== 1'b1)
        begin
            err_total++;
            close_out();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(q, e);
    endtask

    task automatic pulse(input logic [1:0] v);
        {cmin, cmax} <= v;
        tick(1);
        {cmin, cmax} <= 2'h0;
        tick(3);
    endtask

    // Expected {lower, upper} of one phase in wave mode, active high
    function automatic logic [1:0] wave_exp(input logic [1:0] c,
        input logic p, input logic s);
        case (c)
            2'h0: return {p, ~p};
            2'h1: return {p ^ s, 1'b0};
            2'h2: return {1'b0, p};
            default: return {~p, p};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(10);
        rst_i <= 1'b0;
        tick(3);
        chk(32'(gate), 32'h3f);
        for (int i = 0; i < 9; i++)
            rd(8'(4 * i), rst_exp[i]);
        $display("test reset values done");
        for (int p = 0; p < 3; p++)
        begin
            wr(OFS_UNIT, 32'h0);
            wr(OFS_POT, 32'(4 * (3 - p)));
            wr(OFS_UNIT, 32'h8);
            for (int c = 0; c < 4; c++)
            begin
                wr(OFS_OUT, 32'(32'h15 * c));
                tick(8);
                g = {3{c[0] ~^ (p != 1), c[1] ~^ (p != 2)}};
                chk(32'(gate), 32'(g));
            end
        end
        $display("test level mode done");
        wr(OFS_UNIT, 32'h0);
        wr(OFS_POT, 32'hc);
        for (int s = 0; s < 2; s++)
            for (int c = 0; c < 8; c++)
            begin
                wr(OFS_UNIT, 32'(8 + 4 * s));
                wr(OFS_OUT, 32'(32'h40 + c / 2));
                pwm <= {2'h0, c[0]};
                tick(8);
                g = {4'h0, wave_exp(2'(c / 2), c[0], s[0])};
                chk(32'(gate), 32'(g));
            end
        wr(OFS_OUT, 32'h1fc);
        pwm <= 3'h7;
        tick(8);
        chk(32'(gate), 32'h16);
        $display("test wave mode done");
        wr(OFS_UNIT, 32'h0);
        wr(OFS_DT, 32'h2);
        wr(OFS_UNIT, 32'h8);
        wr(OFS_OUT, 32'h43);
        pwm <= 3'h1;
        tick(14);
        pwm <= 3'h0;
        tick(6);
        chk(32'(gate), 32'h0);
        tick(8);
        chk(32'(gate), 32'h2);
        wr(OFS_UNIT, 32'h0);
        wr(OFS_DT, 32'h0);
        $display("test dead time done");
        g = 6'h02;
        for (int u = 1; u < 4; u++)
        begin
            wr(OFS_UNIT, 32'h0);
            wr(OFS_POT, 32'(12 + u));
            wr(OFS_UNIT, 32'h8);
            wr(OFS_OUT, u[0] ? 32'h3f : 32'h0);
            pulse((u == 1) ? 2'h1 : ((u == 2) ? 2'h2 : 2'h0));
            tick(4);
            chk(32'(gate), 32'(g));
            pulse((u == 1) ? 2'h2 : 2'h1);
            tick(4);
            g = u[0] ? 6'h3f : 6'h00;
            chk(32'(gate), 32'(g));
        end
        $display("test update timing done");
        for (int r = 0; r < 4; r++)
        begin
            wr(OFS_UNIT, 32'(8 + r));
            n = pirq_n;
            repeat (4)
            begin
                pulse(2'h2);
                pulse(2'h1);
            end
            tick(4);
            chk(32'(pirq_n - n), 32'(8 >> r));
        end
        $display("test interrupt rate done");
        for (int m = 0; m < 4; m++)
        begin
            wr(OFS_PCTL, 32'(1 + 8 * m));
            wr(OFS_OUT, 32'h3f);
            n = eirq_n;
            trip <= 1'b1;
            tick(12);
            chk(32'(eirq_n - n), 32'h1);
            chk(32'(gate), m[0] ? 32'h0 : 32'h2a);
            chk(32'(pin), (m == 2) ? 32'h2a : 32'h0);
            rd(OFS_PSTA, 32'h1);
            wr(OFS_PCTL, 32'(3 + 8 * m));
            rd(OFS_PSTA, 32'h1);
            trip <= 1'b0;
            tick(8);
            rd(OFS_PSTA, 32'h3);
            wr(OFS_OUT, 32'h0);
            wr(OFS_PCTL, 32'(3 + 8 * m));
            rd(OFS_PSTA, 32'h2);
        end
        $display("test protection done");
        wr(OFS_OUT, 32'h3f);
        halt <= 1'b1;
        tick(8);
        chk(32'({hiz, gate}), 32'h40);
        halt <= 1'b0;
        wr(OFS_BRK, 32'h0);
        halt <= 1'b1;
        tick(8);
        chk(32'(hiz), 32'h0);
        halt <= 1'b0;
        $display("test debug halt done");
        wr(OFS_PCTL, 32'h18);
        rd(OFS_PCTL, 32'h19);
        wr(OFS_KEY, 32'h5a);
        wr(OFS_KEY, 32'ha5);
        wr(OFS_PCTL, 32'h18);
        rd(OFS_PCTL, 32'h18);
        n = eirq_n;
        trip <= 1'b1;
        tick(12);
        chk(32'(eirq_n - n), 32'h0);
        rd(OFS_PSTA, 32'h0);
        trip <= 1'b0;
        $display("test keyed disable done");
        close_out();
    end
endmodule
